// [dou_map.svh]
`ifndef DOU_MAP_SVH
`define DOU_MAP_SVH
// Command and register addresses on the byte-wide register port
`define DOU_ADDR_CONFIG 8'h00
`define DOU_ADDR_CHANNEL 8'h01
`define DOU_ADDR_RAW_LO 8'h02
`define DOU_ADDR_RAW_HI 8'h03
`define DOU_ADDR_STROBE 8'h04
`define DOU_ADDR_STATUS 8'h05
`define DOU_ADDR_CAL_SEL 8'h08
`define DOU_ADDR_CAL_LO 8'h09
`define DOU_ADDR_CAL_HI 8'h0a
`define DOU_ADDR_CAL_RD_LO 8'h0b
`define DOU_ADDR_CAL_RD_HI 8'h0c
`define DOU_ADDR_CAL_RD_MODE 8'h0d
// Configuration byte fields
`define DOU_CFG_RANGE_LSB 0
`define DOU_CFG_RANGE_MSB 2
`define DOU_CFG_MODE_BIT 4
`define DOU_RANGE_DEFAULT 3'h2
`define DOU_RANGE_MAX 3'h5
`define DOU_RANGE_HI_20V 3'h3
`define DOU_MODE_ASYNC 1'b0
`define DOU_MODE_SYNC 1'b1
// Channel and calibration select fields
`define DOU_CH_MSB 2
`define DOU_CAL_FIELD_BIT 4
// Raw codes are 12 bits; the top nibble of the high byte must be zero
`define DOU_CODE_ZERO 12'h000
`define DOU_RAW_HI_OVER_MSB 7
`define DOU_RAW_HI_OVER_LSB 4
// Status byte bits
`define DOU_ST_OK 0
`define DOU_ST_BAD_RANGE 1
`define DOU_ST_BAD_CODE 2
`define DOU_ST_ORPHAN 3
`define DOU_ST_STROBE_IGN 4
`define DOU_ST_SYNC 5
`define DOU_STATUS_RESET 8'h00
// Factory calibration: unity gain, zero offset
`define DOU_FACTORY_GAIN 16'h1000
`define DOU_FACTORY_OFFSET 16'h0000
// Timing
`define DOU_CLK_HZ 50000000
`define DOU_UPDATE_HZ 2500
`endif

// [dou_pkg.sv]
package dou_pkg;
	typedef enum logic [1:0] {
		DOU_SPAN_2V5 = 2'h0,
		DOU_SPAN_5V = 2'h1,
		DOU_SPAN_10V = 2'h3,
		DOU_SPAN_20V = 2'h2
	} dou_span_t;

	typedef struct packed {
		logic sync_mode;
		logic [2:0] range_code;
	} dou_cfg_t;

	typedef struct packed {
		logic [2:0] mode;
		logic [15:0] value;
	} dou_cal_word_t;

	typedef logic [7:0][11:0] dou_codes_t;
endpackage

// [dou_byte_asm.sv]
`timescale 1ns/1ps
module dou_byte_asm
	import dou_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic lo_we_in,
	input wire logic hi_we_in,
	input wire logic [7:0] data_in,
	output logic word_valid_out,
	output logic orphan_out,
	output logic [15:0] word_out
);
	logic [7:0] lo_byte;
	logic lo_pending;

	// Low byte is held until its high byte completes the word
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lo_byte <= 8'h00;
			lo_pending <= 1'b0;
		end else if (lo_we_in) begin
			lo_byte <= data_in;
			lo_pending <= 1'b1;
		end else if (hi_we_in) begin
			lo_pending <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			word_valid_out <= 1'b0;
			orphan_out <= 1'b0;
			word_out <= 16'h0000;
		end else begin
			word_valid_out <= hi_we_in && lo_pending;
			orphan_out <= hi_we_in && !lo_pending;
			if (hi_we_in && lo_pending) begin
				word_out <= {data_in, lo_byte};
			end
		end
	end
endmodule

// [dou_cal_mem.sv]
`timescale 1ns/1ps
module dou_cal_mem
	import dou_pkg::*;
(
	input wire logic clk_in,
	input wire logic wr_en_in,
	input wire logic [3:0] wr_idx_in,
	input wire dou_cal_word_t wr_data_in,
	input wire logic [3:0] rd_idx_in,
	output dou_cal_word_t rd_data_out
);
	// Not reset: contents survive a reset like the stored constants
	dou_cal_word_t mem [16];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_idx_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		rd_data_out <= mem[rd_idx_in];
	end
endmodule

// [dou_ctrl.sv]
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "dou_map.svh"
// Summary of operation
// - Range codes 0 to 5 pick spans for channels 0-1 and 2-7.
// - Range code is 2 after reset, all channels 0-10 V.
// - Asynchronous mode: a raw write updates its channel at once.
// - Synchronous mode: raw writes only fill holding registers.
// - A strobe loads all eight outputs together; unwritten channels give zero.
// - Each valid raw write goes to the channel 0 to 7 selected at its high byte and lands in its register.
// - Raw values arrive as two bytes, assembled before use.
// - Each command returns the status left by the command before it.
// - Gain and offset per channel are kept until a reset, after which they read as factory values.
// - A calibration write replaces the constant, old value lost.
// - Calibration read gives gain, offset and mode of a channel.
// - Eight 12-bit outputs with a 2.5 kHz converter refresh.
// - Raw codes 0 to 4095 are valid, larger ones refused.
// - Strobe acts only in synchronous mode.
module dou_ctrl
	import dou_pkg::*;
#(
	parameter int UPDATE_PERIOD_CYC = `DOU_CLK_HZ / `DOU_UPDATE_HZ
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output dou_codes_t dac_code_out,
	output dou_span_t span_low_group_out,
	output dou_span_t span_high_group_out,
	output logic sync_mode_out,
	output logic refresh_tick_out,
	output logic [7:0] status_out
);
	function automatic dou_span_t span_of(input logic [2:0] code,
			input logic high_group);
		dou_span_t s;
		s = DOU_SPAN_10V;
		if (high_group) begin
			if (code >= `DOU_RANGE_HI_20V) begin
				s = DOU_SPAN_20V;
			end
		end else begin
			case (code)
			3'h0: s = DOU_SPAN_2V5;
			3'h1: s = DOU_SPAN_5V;
			3'h2: s = DOU_SPAN_10V;
			3'h3: s = DOU_SPAN_5V;
			3'h4: s = DOU_SPAN_10V;
			3'h5: s = DOU_SPAN_20V;
			default: s = DOU_SPAN_10V;
			endcase
		end
		return s;
	endfunction

	function automatic logic is_wr(input logic wr, input logic [7:0] addr,
			input logic [7:0] target);
		return wr && (addr == target);
	endfunction

	function automatic logic [7:0] status_base(input logic sync);
		logic [7:0] s;
		s = `DOU_STATUS_RESET;
		s[`DOU_ST_SYNC] = sync;
		return s;
	endfunction

	dou_cfg_t cfg;
	logic [2:0] channel_sel;
	logic [7:0][11:0] holding;
	logic [7:0] cur_status;
	logic [7:0] next_status;
	logic command;
	logic cfg_wr;
	logic strobe_wr;
	logic cal_sel_wr;
	logic cal_commit;
	logic raw_lo_wr;
	logic raw_hi_wr;
	logic raw_valid;
	logic raw_orphan;
	logic [15:0] raw_word;
	logic [2:0] raw_channel;
	logic raw_ok;
	logic [3:0] cal_idx;
	logic [7:0] cal_lo;
	logic [15:0] cal_written;
	dou_cal_word_t cal_wr_data;
	dou_cal_word_t cal_rd_data;
	dou_cal_word_t cal_view;
	logic [14:0] refresh_cnt;
	logic raw_done;
	logic [7:0] raw_status;
	logic cal_rd_written;
	logic cal_rd_offset;

	assign cfg_wr = is_wr(wr_in, addr_in, `DOU_ADDR_CONFIG);
	assign strobe_wr = is_wr(wr_in, addr_in, `DOU_ADDR_STROBE);
	assign cal_sel_wr = is_wr(wr_in, addr_in, `DOU_ADDR_CAL_SEL);
	assign cal_commit = is_wr(wr_in, addr_in, `DOU_ADDR_CAL_HI);
	assign raw_lo_wr = is_wr(wr_in, addr_in, `DOU_ADDR_RAW_LO);
	assign raw_hi_wr = is_wr(wr_in, addr_in, `DOU_ADDR_RAW_HI);

	dou_byte_asm u_asm (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.lo_we_in(raw_lo_wr),
		.hi_we_in(raw_hi_wr),
		.data_in(wdata_in),
		.word_valid_out(raw_valid),
		.orphan_out(raw_orphan),
		.word_out(raw_word)
	);

	// Channel is latched with the high byte so a later select cannot move it
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			raw_channel <= 3'h0;
		end else if (raw_hi_wr) begin
			raw_channel <= channel_sel;
		end
	end

	assign raw_ok = raw_valid &&
		(raw_word[15:12] == 4'h0);

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cfg.range_code <= `DOU_RANGE_DEFAULT;
			cfg.sync_mode <= `DOU_MODE_ASYNC;
		end else if (cfg_wr) begin
			// Reserved bits of the configuration byte are ignored
			if (wdata_in[`DOU_CFG_RANGE_MSB:`DOU_CFG_RANGE_LSB] <=
					`DOU_RANGE_MAX) begin
				cfg.range_code <=
					wdata_in[`DOU_CFG_RANGE_MSB:`DOU_CFG_RANGE_LSB];
			end
			cfg.sync_mode <= wdata_in[`DOU_CFG_MODE_BIT];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			channel_sel <= 3'h0;
		end else if (is_wr(wr_in, addr_in, `DOU_ADDR_CHANNEL)) begin
			channel_sel <= wdata_in[`DOU_CH_MSB:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			holding <= '0;
		end else if (raw_ok) begin
			holding[raw_channel] <= raw_word[11:0];
		end
	end

	// Outputs: immediate in async mode, only on strobe in sync mode
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dac_code_out <= '0;
		end else if (cfg.sync_mode == `DOU_MODE_SYNC) begin
			if (strobe_wr) begin
				dac_code_out <= holding;
			end
		end else if (raw_ok) begin
			dac_code_out[raw_channel] <= raw_word[11:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			span_low_group_out <= span_of(`DOU_RANGE_DEFAULT, 1'b0);
			span_high_group_out <= span_of(`DOU_RANGE_DEFAULT, 1'b1);
			sync_mode_out <= `DOU_MODE_ASYNC;
		end else begin
			span_low_group_out <= span_of(cfg.range_code, 1'b0);
			span_high_group_out <= span_of(cfg.range_code, 1'b1);
			sync_mode_out <= cfg.sync_mode;
		end
	end

	// Converter refresh pacing; codes change at once, the stage resamples
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			refresh_cnt <= 15'h0000;
			refresh_tick_out <= 1'b0;
		end else if (refresh_cnt == 15'(UPDATE_PERIOD_CYC - 1)) begin
			refresh_cnt <= 15'h0000;
			refresh_tick_out <= 1'b1;
		end else begin
			refresh_cnt <= refresh_cnt + 15'h0001;
			refresh_tick_out <= 1'b0;
		end
	end

	// Calibration: select, low byte, then high byte commits the word
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cal_idx <= 4'h0;
			cal_lo <= 8'h00;
		end else begin
			if (cal_sel_wr) begin
				cal_idx <= {wdata_in[`DOU_CH_MSB:0],
					wdata_in[`DOU_CAL_FIELD_BIT]};
			end
			if (is_wr(wr_in, addr_in, `DOU_ADDR_CAL_LO)) begin
				cal_lo <= wdata_in;
			end
		end
	end

	always_comb begin
		cal_wr_data.value = {wdata_in, cal_lo};
		cal_wr_data.mode = cfg.range_code;
	end

	dou_cal_mem u_cal (
		.clk_in(clk_in),
		.wr_en_in(cal_commit),
		.wr_idx_in(cal_idx),
		.wr_data_in(cal_wr_data),
		.rd_idx_in(cal_idx),
		.rd_data_out(cal_rd_data)
	);

	// Unwritten entries read as factory values; memory has no reset
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cal_written <= 16'h0000;
		end else if (cal_commit) begin
			cal_written[cal_idx] <= 1'b1;
		end
	end

	// Mask and select are registered to line up with the memory's read data
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cal_rd_written <= 1'b0;
			cal_rd_offset <= 1'b0;
		end else begin
			cal_rd_written <= cal_written[cal_idx];
			cal_rd_offset <= cal_idx[0];
		end
	end

	always_comb begin
		cal_view = cal_rd_data;
		if (!cal_rd_written) begin
			cal_view.mode = `DOU_RANGE_DEFAULT;
			cal_view.value = cal_rd_offset ? `DOU_FACTORY_OFFSET :
				`DOU_FACTORY_GAIN;
		end
	end

	// Status of each command; the previous one is what gets returned
	assign command = cfg_wr || strobe_wr || cal_sel_wr || cal_commit;
	assign raw_done = raw_valid || raw_orphan;

	// A raw value reports one cycle after its high byte
	always_comb begin
		raw_status = status_base(cfg.sync_mode);
		if (raw_orphan) begin
			raw_status[`DOU_ST_ORPHAN] = 1'b1;
		end else if (raw_ok) begin
			raw_status[`DOU_ST_OK] = 1'b1;
		end else begin
			raw_status[`DOU_ST_BAD_CODE] = 1'b1;
		end
	end

	always_comb begin
		next_status = status_base(cfg.sync_mode);
		if (cfg_wr) begin
			next_status[`DOU_ST_SYNC] = wdata_in[`DOU_CFG_MODE_BIT];
			if (wdata_in[`DOU_CFG_RANGE_MSB:`DOU_CFG_RANGE_LSB] >
					`DOU_RANGE_MAX) begin
				next_status[`DOU_ST_BAD_RANGE] = 1'b1;
			end else begin
				next_status[`DOU_ST_OK] = 1'b1;
			end
		end else if (strobe_wr) begin
			if (cfg.sync_mode == `DOU_MODE_SYNC) begin
				next_status[`DOU_ST_OK] = 1'b1;
			end else begin
				next_status[`DOU_ST_STROBE_IGN] = 1'b1;
			end
		end else begin
			next_status[`DOU_ST_OK] = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cur_status <= `DOU_STATUS_RESET;
			status_out <= `DOU_STATUS_RESET;
		end else if (raw_done && command) begin
			// Both in one cycle: the raw value came first, so it is returned
			status_out <= raw_status;
			cur_status <= next_status;
		end else if (raw_done) begin
			status_out <= cur_status;
			cur_status <= raw_status;
		end else if (command) begin
			status_out <= cur_status;
			cur_status <= next_status;
		end
	end

	// Read data stand in the cycle after the strobe only
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			if (addr_in == `DOU_ADDR_CONFIG) begin
				rdata_out <= {3'h0, cfg.sync_mode, 1'b0, cfg.range_code};
			end else if (addr_in == `DOU_ADDR_CHANNEL) begin
				rdata_out <= {5'h00, channel_sel};
			end else if (addr_in == `DOU_ADDR_STATUS) begin
				rdata_out <= status_out;
			end else if (addr_in == `DOU_ADDR_CAL_SEL) begin
				rdata_out <= {3'h0, cal_idx[0], 1'b0, cal_idx[3:1]};
			end else if (addr_in == `DOU_ADDR_CAL_RD_LO) begin
				rdata_out <= cal_view.value[7:0];
			end else if (addr_in == `DOU_ADDR_CAL_RD_HI) begin
				rdata_out <= cal_view.value[15:8];
			end else if (addr_in == `DOU_ADDR_CAL_RD_MODE) begin
				rdata_out <= {5'h00, cal_view.mode};
			end else begin
				rdata_out <= 8'h00;
			end
		end else begin
			rdata_out <= 8'h00;
		end
	end
endmodule

// [dou_ctrl_assertions.sv]
`timescale 1ns/1ps
`include "dou_map.svh"
module dou_chk
	import dou_pkg::*;
#(
	parameter int UPDATE_PERIOD_CYC = `DOU_CLK_HZ / `DOU_UPDATE_HZ
)
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [7:0] rdata_out,
	input wire dou_codes_t dac_code_out,
	input wire dou_span_t span_low_group_out,
	input wire dou_span_t span_high_group_out,
	input wire logic sync_mode_out,
	input wire logic refresh_tick_out,
	input wire logic [7:0] status_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic [15:0] gap;
	logic seen;
	function automatic dou_span_t lo_span(input logic [2:0] r);
		case (r)
			3'h0: return DOU_SPAN_2V5;
			3'h1, 3'h3: return DOU_SPAN_5V;
			3'h2, 3'h4: return DOU_SPAN_10V;
			default: return DOU_SPAN_20V;
		endcase
	endfunction
	// First tick after reset has no known phase, so only gaps are judged
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gap <= 16'h0000;
			seen <= 1'b0;
		end else if (refresh_tick_out) begin
			gap <= 16'h0001;
			seen <= 1'b1;
		end else begin
			gap <= gap + 16'h0001;
		end
	end
	sequence cfg_wr;
		wr_in && addr_in == `DOU_ADDR_CONFIG;
	endsequence
	sequence good_cfg;
		cfg_wr ##0 wdata_in[2:0] <= `DOU_RANGE_MAX;
	endsequence
	sequence bad_cfg;
		cfg_wr ##0 wdata_in[2:0] > `DOU_RANGE_MAX;
	endsequence
	rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data outside read slot");
	reset_dflt_a: assert property ($past(!rst_n_in) |->
		span_low_group_out == DOU_SPAN_10V && !sync_mode_out &&
		span_high_group_out == DOU_SPAN_10V && dac_code_out == '0)
		else $error("wrong state after reset");
	span_grp_a: assert property (span_high_group_out inside
		{DOU_SPAN_10V, DOU_SPAN_20V}) else $error("bad high group span");
	cfg_span_a: assert property (good_cfg |-> ##2
		span_low_group_out == lo_span($past(wdata_in[2:0], 2)) &&
		span_high_group_out == (($past(wdata_in[2:0], 2) >=
		`DOU_RANGE_HI_20V) ? DOU_SPAN_20V : DOU_SPAN_10V))
		else $error("span does not follow range code");
	cfg_mode_a: assert property (cfg_wr |-> ##2
		sync_mode_out == $past(wdata_in[`DOU_CFG_MODE_BIT], 2))
		else $error("mode does not follow config");
	range_kept_a: assert property (bad_cfg |-> ##2
		$stable(span_low_group_out) && $stable(span_high_group_out) &&
		sync_mode_out == $past(wdata_in[`DOU_CFG_MODE_BIT], 2))
		else $error("bad range code changed spans");
	sync_hold_a: assert property (sync_mode_out && $past(sync_mode_out) &&
		!$past(wr_in && addr_in == `DOU_ADDR_STROBE) |-> $stable(dac_code_out))
		else $error("output moved without strobe");
	tick_gap_a: assert property (refresh_tick_out && seen |->
		gap == UPDATE_PERIOD_CYC) else $error("refresh period wrong");
	tick_max_a: assert property (seen |-> gap <= UPDATE_PERIOD_CYC)
		else $error("refresh tick missing");
endmodule
bind dou_ctrl dou_chk #(.UPDATE_PERIOD_CYC(UPDATE_PERIOD_CYC)) chk (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
	.rdata_out(rdata_out), .dac_code_out(dac_code_out),
	.span_low_group_out(span_low_group_out),
	.span_high_group_out(span_high_group_out),
	.sync_mode_out(sync_mode_out), .refresh_tick_out(refresh_tick_out),
	.status_out(status_out));

// [dou_master.sv]
`timescale 1ns/1ps
`include "dou_map.svh"
module dou_master (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// Idle cycle after each strobe keeps one assignment per time step
	task put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
	endtask
	task get(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(posedge clk_in);
		d = rdata_in;
	endtask
	task cfg(input logic m, input logic [2:0] r);
		put(`DOU_ADDR_CONFIG, {3'h0, m, 1'b0, r});
	endtask
	task raw(input logic [2:0] ch, input logic [11:0] v);
		put(`DOU_ADDR_CHANNEL, {5'h00, ch});
		put(`DOU_ADDR_RAW_LO, v[7:0]);
		put(`DOU_ADDR_RAW_HI, {4'h0, v[11:8]});
	endtask
	task strobe();
		put(`DOU_ADDR_STROBE, 8'h00);
	endtask
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`include "dou_map.svh"
module testbench
	import dou_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [7:0] addr, wdata, rdata, status, rv, lo, hi;
	logic wr, rd, sync, tick;
	dou_codes_t dac;
	dou_span_t span_lo, span_hi;
	int n_fail = 0;
	int n_checks = 0;
	int k;
	dou_span_t lo_tab [6] = '{DOU_SPAN_2V5, DOU_SPAN_5V, DOU_SPAN_10V,
		DOU_SPAN_5V, DOU_SPAN_10V, DOU_SPAN_20V};
	dou_ctrl #(.UPDATE_PERIOD_CYC(8)) uut (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
		.rd_in(rd), .rdata_out(rdata), .dac_code_out(dac),
		.span_low_group_out(span_lo), .span_high_group_out(span_hi),
		.sync_mode_out(sync), .refresh_tick_out(tick), .status_out(status));
	dou_master m (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
		.wdata_out(wdata), .wr_out(wr), .rd_out(rd));
	initial begin
		forever #10 clk_in = ~clk_in;
	end
	task summarize();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	task w(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task calrd(input logic [7:0] sel, input logic [15:0] e,
		input logic [7:0] em);
		m.put(`DOU_ADDR_CAL_SEL, sel);
		m.get(`DOU_ADDR_CAL_RD_LO, lo);
		m.get(`DOU_ADDR_CAL_RD_HI, hi);
		m.get(`DOU_ADDR_CAL_RD_MODE, rv);
		chk("cal", e, {hi, lo});
		chk("cal_mode", em, rv);
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		w(1);
		chk("span_lo", DOU_SPAN_10V, span_lo);
		chk("span_hi", DOU_SPAN_10V, span_hi);
		chk("sync", 1'b0, sync);
		m.get(8'h07, rv);
		chk("unmapped", 8'h00, rv);
		$display("test reset done");
		for (int r = 0; r < 8; r++) begin
			m.cfg(1'b0, r[2:0]);
			w(3);
			chk("span_lo", lo_tab[r > 5 ? 5 : r], span_lo);
			chk("span_hi", r > 2 ? DOU_SPAN_20V : DOU_SPAN_10V, span_hi);
		end
		m.cfg(1'b0, 3'h2);
		w(3);
		chk("st_range", 1'b1, status[`DOU_ST_BAD_RANGE]);
		$display("test range done");
		for (int c = 0; c < 8; c++) begin
			m.raw(c[2:0], {c[2:0], 9'h1ff});
			w(3);
		end
		for (int c = 0; c < 8; c++) begin
			chk("code", {c[2:0], 9'h1ff}, dac[c]);
		end
		m.put(`DOU_ADDR_RAW_LO, 8'h00);
		m.put(`DOU_ADDR_RAW_HI, 8'h10);
		w(3);
		chk("code7", 12'hfff, dac[7]);
		m.put(`DOU_ADDR_RAW_HI, 8'h01);
		w(2);
		chk("st_code", 1'b1, status[`DOU_ST_BAD_CODE]);
		m.strobe();
		w(3);
		chk("code7", 12'hfff, dac[7]);
		chk("st_orphan", 8'h08, status);
		m.get(`DOU_ADDR_STATUS, rv);
		chk("st_read", 8'h08, rv);
		$display("test async done");
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rst_n_in <= 1'b1;
		m.cfg(1'b1, 3'h2);
		m.raw(3'h3, 12'h123);
		w(3);
		chk("sync", 1'b1, sync);
		chk("code3", 12'h000, dac[3]);
		m.strobe();
		w(2);
		for (int c = 0; c < 8; c++) begin
			chk("code", c == 3 ? 12'h123 : 12'h000, dac[c]);
		end
		m.raw(3'h1, 12'h555);
		w(3);
		chk("code1", 12'h000, dac[1]);
		m.cfg(1'b0, 3'h4);
		w(3);
		m.strobe();
		w(3);
		chk("code1", 12'h000, dac[1]);
		$display("test sync done");
		calrd(8'h02, `DOU_FACTORY_GAIN, 8'h02);
		chk("st_ign", 8'h10, status);
		m.put(`DOU_ADDR_CAL_LO, 8'h34);
		m.put(`DOU_ADDR_CAL_HI, 8'h12);
		calrd(8'h02, 16'h1234, 8'h04);
		calrd(8'h12, `DOU_FACTORY_OFFSET, 8'h02);
		$display("test cal done");
		// A missing tick ends both loops at their bound and fails the count
		for (k = 0; k < 20 && tick !== 1'b1; k++) w(1);
		w(1);
		for (k = 1; k < 20 && tick !== 1'b1; k++) w(1);
		chk("tick_gap", 16'h0008, k[15:0]);
		$display("test tick done");
		summarize();
	end
endmodule
